//--- rtl/watch_debug_ctrl.sv
// watchpoint control comparison, halt control/status, vector trap, single step
// assumes scan accesses arrive already synchronised to clock as one-cycle strobes
// Notes on behaviour
// - sel bit 3 picks data or fetch attributes
// - bit 3 never masked, bit 8 always masked out of the compare
// - bit 0 compares data direction
// - bits 2:1 compare data access size
// - data mode bit 4 compares data privilege
// - fetch mode bit 4 compares fetch privilege
// - fetch mode bit 2 compares compressed state
// - bit 5 compares per-unit external condition
// - unit 0 bit 6 compares unit 1 chain
// - chain latch loads data match on addr and control match
// - chain latch clears on value write, reset
// - unit 0 bit 7 compares unit 1 pair
// - watchpoint break asserted only when the unit's enable bit set
// - halt control four bits step irqdis req ack
// - status written on write, read otherwise
// - status 1:0 req/ack, 2 irq enable
// - status 3 shows synchronised memory request
// - status 4 shows compressed state flag
// - eight trap bits, one per exception
// - trapped vector fetch forces breakpoint
// - only exception-entry vector fetches trap
// - step runs one instruction then re-halts
// - sel bit steers fetch or data break
// - mask bit 3 reads zero, never set
`timescale 1ns/1ps
`default_nettype none
`include "watch_debug_regs.svh"
module watch_debug_ctrl (
    input wire logic clock, // 200 MHz core clock
    input wire logic rst_n, // async active-low reset
    input wire logic test_reset_n, // test logic reset, low clears chain latch
    input wire watch_debug_pkg::scan_access_t scan_in, // register access
    output logic [31:0] scan_rdata, // read data, registered
    input wire watch_debug_pkg::core_attr_t attr, // core bus attributes
    input wire logic [1:0] addr_hit, // per unit address-field match
    input wire logic [1:0] data_hit, // per unit data-field match
    input wire logic external_condition_zero, // unit 0 external condition
    input wire logic external_condition_one, // unit 1 external condition
    input wire logic halt_acknowledge, // core in debug state
    input wire logic core_irq_enable_state, // core interrupt enable
    input wire logic mem_request_n, // core memory request, active low
    input wire logic [7:0] vector_fetch, // one-hot exception vector fetch
    input wire logic exception_entry, // fetch is part of exception entry
    input wire logic insn_done, // core completed one instruction
    output logic fetch_break_hit, // instruction-side breakpoint
    output logic data_break_hit, // data-side breakpoint
    output logic vector_break, // trap forced breakpoint
    output logic step_break, // step re-entry request
    output logic halt_request, // debug request to core
    output logic irq_mask_in_debug, // interrupts disabled
    output logic link_latch_out, // unit 1 chain output
    output logic pair_out // unit 1 range output
);
    import watch_debug_pkg::*;

    // reset release through two flops
    // asserts at once, releases on an edge, so no flop sees a ragged release
    logic rst_s1, rst_sync_n;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1 <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_sync_n <= rst_s1;
        end
    end

    // registers
    logic [8:0] val_reg [2]; // control value per unit
    logic [7:0] msk_reg [2]; // control mask per unit
    logic [3:0] halt_control_reg; // step, irqdis, req, ack
    logic [7:0] exception_trap_select_reg; // one bit per vector
    logic [4:0] halt_status_reg; // writable status shadow
    logic [1:0] link_reg; // chain latch per unit
    step_state_t step_reg, step_next; // step sequencer

    // synchronisers for status; first stages read only by second stages
    logic ack_s1, ack_s2, mreq_s1, mreq_s2;
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack_s1 <= 1'b0;
            ack_s2 <= 1'b0;
            mreq_s1 <= 1'b1;
            mreq_s2 <= 1'b1;
        end else begin
            ack_s1 <= halt_acknowledge;
            ack_s2 <= ack_s1;
            mreq_s1 <= mem_request_n;
            mreq_s2 <= mreq_s1;
        end
    end

    // access decode
    // one strobe carries either a write or a read, never both
    wire wr = scan_in.strobe && scan_in.write;
    wire rd = scan_in.strobe && !scan_in.write;
    wire wr_hc = wr && (scan_in.addr == `ADDR_HALT_CTRL);
    wire wr_hs = wr && (scan_in.addr == `ADDR_HALT_STAT);
    wire wr_ts = wr && (scan_in.addr == `ADDR_TRAP_SEL);
    wire [1:0] wr_val = {wr && (scan_in.addr == `ADDR_WP1_CTRL_VAL),
                         wr && (scan_in.addr == `ADDR_WP0_CTRL_VAL)};
    wire [1:0] wr_msk = {wr && (scan_in.addr == `ADDR_WP1_CTRL_MSK),
                         wr && (scan_in.addr == `ADDR_WP0_CTRL_MSK)};

    // compare one unit's control field; mask one means don't care
    function automatic logic ctrl_match(input logic [8:0] v, input logic [7:0] m,
                                        input logic [8:0] obs);
        logic [8:0] eff_m;
        eff_m = {1'b1, m};
        eff_m[`CB_SEL] = 1'b0;
        eff_m[`CB_ENABLE] = 1'b1; // enable gates output, not the compare
        ctrl_match = &(~(v ^ obs) | eff_m);
    endfunction : ctrl_match

    // observed control vector per unit, selected by bit 3
    function automatic logic [8:0] observed(input logic sel, input core_attr_t a,
                                            input logic ext, input logic chn,
                                            input logic rng);
        logic [8:0] o;
        o = 9'h000;
        o[`CB_SEL] = sel;
        o[`CB_EXT] = ext;
        o[`CB_CHAIN] = chn;
        o[`CB_RANGE] = rng;
        if (sel) begin
            o[`CB_DIR] = a.data_dir;
            o[`CB_SIZE_HI:`CB_SIZE_LO] = a.data_size;
            o[`CB_PRIV] = a.data_priv;
        end else begin
            o[`CB_PRIV] = a.fetch_priv;
            o[`CB_SIZE_HI] = a.compressed;
        end
        observed = o;
    endfunction : observed

    // hit terms declared ahead of the observed vectors that read them
    wire [1:0] ac_hit; // address and control field match per unit
    wire pair_comb; // unit 1 full match, fed live to unit 0
    // unit 1 feeds unit 0 chain and range; unit 1 own inputs tied low
    // pair stays combinational so both units can match in the same cycle
    wire [8:0] obs1 = observed(val_reg[1][`CB_SEL], attr, external_condition_one,
                               1'b0, 1'b0);
    wire [8:0] obs0 = observed(val_reg[0][`CB_SEL], attr, external_condition_zero,
                               link_reg[1], pair_comb);
    assign ac_hit[1] = addr_hit[1] && ctrl_match(val_reg[1], msk_reg[1], obs1);
    assign ac_hit[0] = addr_hit[0] && ctrl_match(val_reg[0], msk_reg[0], obs0);
    assign pair_comb = ac_hit[1] && data_hit[1];
    wire [1:0] hit = {pair_comb, ac_hit[0] && data_hit[0]};
    // enabled hits steered by selection bit
    wire [1:0] en_hit = {hit[1] && val_reg[1][`CB_ENABLE],
                         hit[0] && val_reg[0][`CB_ENABLE]};
    wire [1:0] is_data = {val_reg[1][`CB_SEL], val_reg[0][`CB_SEL]};
    wire fbh_next = |(en_hit & ~is_data);
    wire dbh_next = |(en_hit & is_data);
    // trap: reserved bit never fires, only exception-entry fetches count
    wire [7:0] trap_mask = exception_trap_select_reg & ~(8'h01 << `TRAP_RESERVED);
    wire vec_next = exception_entry && |(vector_fetch & trap_mask);

    // watchpoint registers and chain latches
    // a clear and a load in one cycle: the clear wins
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            val_reg[0] <= `RST_CTRL_VAL;
            val_reg[1] <= `RST_CTRL_VAL;
            msk_reg[0] <= `RST_CTRL_MSK;
            msk_reg[1] <= `RST_CTRL_MSK;
            link_reg <= 2'b00;
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (wr_val[u])
                    val_reg[u] <= scan_in.wdata[8:0];
                if (wr_msk[u])
                    msk_reg[u] <= scan_in.wdata[7:0] & ~(8'h01 << `CB_SEL);
                if (!test_reset_n || wr_val[u])
                    link_reg[u] <= 1'b0;
                else if (ac_hit[u])
                    link_reg[u] <= data_hit[u];
            end
        end
    end

    // halt control, status shadow, trap select
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            halt_control_reg <= `RST_HALT_CTRL;
            exception_trap_select_reg <= `RST_TRAP_SEL;
            halt_status_reg <= `RST_HALT_STAT;
        end else begin
            if (wr_hc)
                halt_control_reg <= scan_in.wdata[3:0];
            if (wr_ts)
                exception_trap_select_reg <= scan_in.wdata[7:0];
            if (wr_hs)
                halt_status_reg <= scan_in.wdata[4:0];
        end
    end

    // live status view; writes land in the shadow, reads see live state
    // the irq enable bit uses the synchronised ack, never the raw pin
    wire [4:0] status_live = {attr.compressed, mreq_s2,
                              core_irq_enable_state && !ack_s2,
                              halt_control_reg[`HC_REQ], ack_s2};

    // read data register; unmapped index reads zero
    // only a read strobe loads the register, so the last answer holds
    wire [31:0] rd_mux =
        (scan_in.addr == `ADDR_HALT_CTRL) ? {28'h0, halt_control_reg} :
        (scan_in.addr == `ADDR_HALT_STAT) ? {27'h0, status_live} :
        (scan_in.addr == `ADDR_TRAP_SEL) ? {24'h0, exception_trap_select_reg} :
        (scan_in.addr == `ADDR_WP0_CTRL_VAL) ? {23'h0, val_reg[0]} :
        (scan_in.addr == `ADDR_WP0_CTRL_MSK) ? {24'h0, msk_reg[0]} :
        (scan_in.addr == `ADDR_WP1_CTRL_VAL) ? {23'h0, val_reg[1]} :
        (scan_in.addr == `ADDR_WP1_CTRL_MSK) ? {24'h0, msk_reg[1]} : 32'h0;

    // single step: armed while halted with step set, run after exit
    // limitation: a step bit set while running waits for the next halt
    always_comb begin
        step_next = step_reg;
        case (step_reg)
            ST_IDLE: if (ack_s2 && halt_control_reg[`HC_STEP]) step_next = ST_ARMED;
            ST_ARMED: begin
                if (!halt_control_reg[`HC_STEP]) step_next = ST_IDLE;
                else if (!ack_s2) step_next = ST_RUN;
            end
            ST_RUN: if (insn_done) step_next = ST_IDLE;
            default: step_next = ST_IDLE;
        endcase
    end

    // registered outputs
    // each break output stands one cycle per cause cycle
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            step_reg <= ST_IDLE;
            scan_rdata <= 32'h0;
            fetch_break_hit <= 1'b0;
            data_break_hit <= 1'b0;
            vector_break <= 1'b0;
            step_break <= 1'b0;
        end else begin
            step_reg <= step_next;
            if (rd)
                scan_rdata <= rd_mux;
            fetch_break_hit <= fbh_next;
            data_break_hit <= dbh_next;
            vector_break <= vec_next;
            step_break <= (step_reg == ST_RUN) && insn_done;
        end
    end

    assign halt_request = halt_control_reg[`HC_REQ];
    assign irq_mask_in_debug = halt_control_reg[`HC_IRQDIS];
    assign link_latch_out = link_reg[1];
    assign pair_out = pair_comb;

    // assertions
    property p_enable_gate;
        @(posedge clock) disable iff (!rst_sync_n)
        (fbh_next || dbh_next) |-> (val_reg[0][`CB_ENABLE] || val_reg[1][`CB_ENABLE]);
    endproperty
    a_enable_gate: assert property (p_enable_gate) else $error("break without enable");
    property p_data_steer;
        @(posedge clock) disable iff (!rst_sync_n)
        data_break_hit |-> $past(|(en_hit & is_data));
    endproperty
    a_data_steer: assert property (p_data_steer) else $error("data steer wrong");
    property p_mask_bit3;
        @(posedge clock) disable iff (!rst_sync_n)
        !msk_reg[0][`CB_SEL] && !msk_reg[1][`CB_SEL];
    endproperty
    a_mask_bit3: assert property (p_mask_bit3) else $error("mask bit 3 set");
    property p_chain_clear;
        @(posedge clock) disable iff (!rst_sync_n)
        wr_val[1] |=> !link_reg[1];
    endproperty
    a_chain_clear: assert property (p_chain_clear) else $error("chain not cleared");
    property p_chain_load;
        @(posedge clock) disable iff (!rst_sync_n)
        (test_reset_n && !wr_val[1] && ac_hit[1]) |=> (link_reg[1] == $past(data_hit[1]));
    endproperty
    a_chain_load: assert property (p_chain_load) else $error("chain load wrong");
    property p_vec_entry;
        @(posedge clock) disable iff (!rst_sync_n)
        vector_break |-> $past(exception_entry);
    endproperty
    a_vec_entry: assert property (p_vec_entry) else $error("trap outside entry");
    property p_vec_fire;
        @(posedge clock) disable iff (!rst_sync_n)
        (exception_entry && |(vector_fetch & trap_mask)) |=> vector_break;
    endproperty
    a_vec_fire: assert property (p_vec_fire) else $error("trap missed");
    sequence s_step_run;
        step_reg == ST_RUN ##0 insn_done;
    endsequence
    property p_step;
        @(posedge clock) disable iff (!rst_sync_n)
        s_step_run |=> step_break ##1 !step_break;
    endproperty
    a_step: assert property (p_step) else $error("step re-entry wrong");
    property p_status_read;
        @(posedge clock) disable iff (!rst_sync_n)
        (rd && scan_in.addr == `ADDR_HALT_STAT) |=> scan_rdata[3] == $past(mreq_s2);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status read wrong");

    // status reads share one antecedent
    sequence s_status_read;
        rd && scan_in.addr == `ADDR_HALT_STAT;
    endsequence

    // ack from the synchroniser, request from the control word
    property p_status_low;
        @(posedge clock) disable iff (!rst_sync_n)
        s_status_read |=> scan_rdata[1:0] == $past({halt_control_reg[`HC_REQ], ack_s2});
    endproperty
    a_status_low: assert property (p_status_low) else $error("status bits wrong");

    // instruction-set state flag on top of the status word
    property p_status_state;
        @(posedge clock) disable iff (!rst_sync_n)
        s_status_read |=> scan_rdata[4] == $past(attr.compressed);
    endproperty
    a_status_state: assert property (p_status_state) else $error("state bit wrong");

    // a status write lands in the shadow only
    property p_status_write;
        @(posedge clock) disable iff (!rst_sync_n)
        wr_hs |=> halt_status_reg == $past(scan_in.wdata[4:0]);
    endproperty
    a_status_write: assert property (p_status_write) else $error("shadow wrong");

    // request and irq mask follow the written control word
    property p_halt_write;
        @(posedge clock) disable iff (!rst_sync_n)
        wr_hc |=> halt_request == $past(scan_in.wdata[`HC_REQ])
            && irq_mask_in_debug == $past(scan_in.wdata[`HC_IRQDIS]);
    endproperty
    a_halt_write: assert property (p_halt_write) else $error("halt control wrong");

    // the reserved vector never traps
    property p_trap_reserved;
        @(posedge clock) disable iff (!rst_sync_n)
        (exception_entry && vector_fetch == (8'h01 << `TRAP_RESERVED)) |=> !vector_break;
    endproperty
    a_trap_reserved: assert property (p_trap_reserved) else $error("reserved trap");

    // test logic reset empties both chain latches
    property p_chain_trst;
        @(posedge clock) disable iff (!rst_sync_n)
        !test_reset_n |=> link_reg == 2'b00;
    endproperty
    a_chain_trst: assert property (p_chain_trst) else $error("test reset missed");

    // fetch break only from a fetch-mode unit
    property p_fetch_steer;
        @(posedge clock) disable iff (!rst_sync_n)
        fetch_break_hit |-> $past(|(en_hit & ~is_data));
    endproperty
    a_fetch_steer: assert property (p_fetch_steer) else $error("fetch steer wrong");

    // clearing the step bit before exit disarms the sequencer
    property p_step_disarm;
        @(posedge clock) disable iff (!rst_sync_n)
        (step_reg == ST_ARMED && !halt_control_reg[`HC_STEP]) |=> step_reg == ST_IDLE;
    endproperty
    a_step_disarm: assert property (p_step_disarm) else $error("step not disarmed");
endmodule : watch_debug_ctrl
`default_nettype wire

//--- rtl/watch_debug_pkg.sv
// types shared by the watchpoint and halt control block
// assumes the _regs header for numeric constants
package watch_debug_pkg;
    // one scan access to a register
    typedef struct packed {
        logic strobe; // one-cycle access pulse
        logic write; // high for write
        logic [4:0] addr; // register index
        logic [31:0] wdata; // scanned-in value
    } scan_access_t;
    // core bus attributes seen by the comparators
    typedef struct packed {
        logic data_dir; // 0 read, 1 write
        logic [1:0] data_size; // access size
        logic data_priv; // 0 user, 1 privileged
        logic fetch_priv; // 0 user, 1 privileged
        logic compressed; // compressed fetch
    } core_attr_t;
    // single-step sequencer states, one bit flips per step except RUN back to IDLE
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b11
    } step_state_t;
endpackage : watch_debug_pkg

//--- rtl/watch_debug_regs.svh
// constants for the watchpoint and halt control block
// assumes inclusion by bare name from rtl/
`ifndef WATCH_DEBUG_REGS_SVH
`define WATCH_DEBUG_REGS_SVH
// scan register addresses (5-bit index)
`define ADDR_HALT_CTRL 5'h00
`define ADDR_HALT_STAT 5'h01
`define ADDR_TRAP_SEL 5'h02
`define ADDR_WP0_CTRL_VAL 5'h0c
`define ADDR_WP0_CTRL_MSK 5'h0d
`define ADDR_WP1_CTRL_VAL 5'h14
`define ADDR_WP1_CTRL_MSK 5'h15
// control field bit positions
`define CB_DIR 0
`define CB_SIZE_LO 1
`define CB_SIZE_HI 2
`define CB_SEL 3
`define CB_PRIV 4
`define CB_EXT 5
`define CB_CHAIN 6
`define CB_RANGE 7
`define CB_ENABLE 8
// halt control bit positions
`define HC_ACK 0
`define HC_REQ 1
`define HC_IRQDIS 2
`define HC_STEP 3
// reset values
`define RST_CTRL_VAL 9'h000
`define RST_CTRL_MSK 8'h00
`define RST_HALT_CTRL 4'h0
`define RST_HALT_STAT 5'h00
`define RST_TRAP_SEL 8'h00
// reserved trap bit
`define TRAP_RESERVED 5
`endif

//--- verification/scan_host_model.sv
// debugger-side model: one-cycle scan accesses into the block
// assumes the bench calls its tasks from the block clock domain
`timescale 1ns/1ps
`default_nettype none
`include "watch_debug_regs.svh"
module scan_host_model (
    input wire logic clock, // block clock
    input wire logic halted, // core in debug state
    input wire logic [31:0] rdata, // read data from block
    output var watch_debug_pkg::scan_access_t scan // access to block
);
    import watch_debug_pkg::*;
    logic [1:0] fetch_mode = 2'b11; // units in fetch mode after reset
    logic step_bit = 1'b0; // last step bit sent
    initial scan = '0;
    // strobe for one edge, released data goes to its inverse
    task automatic access(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        #1;
        scan = '{strobe: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clock);
        #1;
        scan.strobe = 1'b0;
        scan.wdata = ~d;
    endtask : access
    // write, keeping the debugger's own duties
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] v;
        v = d;
        if (a == `ADDR_WP0_CTRL_VAL) fetch_mode[0] = ~d[`CB_SEL];
        if (a == `ADDR_WP1_CTRL_VAL) fetch_mode[1] = ~d[`CB_SEL];
        // direction and low size bit are don't-care for fetch compares
        if ((a == `ADDR_WP0_CTRL_MSK && fetch_mode[0]) ||
            (a == `ADDR_WP1_CTRL_MSK && fetch_mode[1])) v[1:0] = 2'b11;
        // step bit only moves while halted
        if (a == `ADDR_HALT_CTRL && !halted) v[`HC_STEP] = step_bit;
        if (a == `ADDR_HALT_CTRL) step_bit = v[`HC_STEP];
        access(1'b1, a, v);
    endtask : wr
    // read, sampled one edge after the strobe is taken
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        access(1'b0, a, 32'h0);
        @(posedge clock);
        #1;
        d = rdata;
    endtask : rd
endmodule : scan_host_model
`default_nettype wire

//--- verification/watchpoint_debug_control_bench.sv
// self-checking bench for the watchpoint and halt control block
// assumes the scan host model and the design sources are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "watch_debug_regs.svh"
module watchpoint_debug_control_bench;
    import watch_debug_pkg::*;
    logic clock, rst_n, test_reset_n, ext0, ext1, ack, irq_en, mreq_n;
    logic exc_entry, insn_done, fbrk, dbrk, vbrk, sbrk, hreq, imask, link, pair;
    scan_access_t scan; // host access
    core_attr_t attr; // core attributes
    core_attr_t good; // attributes matching unit 1
    logic [31:0] rdata, v;
    logic [1:0] addr_hit, data_hit;
    logic [7:0] vfetch;
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int i;
    watch_debug_ctrl u_dut (.clock(clock), .rst_n(rst_n), .test_reset_n(test_reset_n),
        .scan_in(scan), .scan_rdata(rdata), .attr(attr), .addr_hit(addr_hit),
        .data_hit(data_hit), .external_condition_zero(ext0),
        .external_condition_one(ext1), .halt_acknowledge(ack),
        .core_irq_enable_state(irq_en), .mem_request_n(mreq_n), .vector_fetch(vfetch),
        .exception_entry(exc_entry), .insn_done(insn_done), .fetch_break_hit(fbrk),
        .data_break_hit(dbrk), .vector_break(vbrk), .step_break(sbrk),
        .halt_request(hreq), .irq_mask_in_debug(imask), .link_latch_out(link),
        .pair_out(pair));
    scan_host_model u_host (.clock(clock), .halted(ack), .rdata(rdata), .scan(scan));
    // free-running core clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit
    // one-cycle vector fetch, break checked the cycle after
    task automatic pulse_vec(input logic [7:0] f, input logic e);
        vfetch = f;
        exc_entry = e;
        tick(1);
        vfetch = 8'h00;
        exc_entry = 1'b0;
    endtask : pulse_vec
    task automatic end_sim;
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    // hang guard, well above the expected run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            end_sim();
        end
    end
    initial begin
        {rst_n, ext0, ext1, ack, irq_en, exc_entry, insn_done} = '0;
        {test_reset_n, mreq_n} = 2'b11;
        {addr_hit, data_hit, vfetch} = '0;
        attr = '0;
        good = '{data_dir: 1'b1, data_size: 2'b10, data_priv: 1'b1, fetch_priv: 1'b0,
            compressed: 1'b1};
        repeat (20) @(posedge clock);
        #1 rst_n = 1'b1;
        tick(4);
        // halt control drives request and irq mask
        u_host.wr(`ADDR_HALT_CTRL, 32'h6);
        tick(1);
        chk_bit(hreq, 1'b1);
        chk_bit(imask, 1'b1);
        u_host.rd(`ADDR_HALT_CTRL, v);
        chk_word(v, 32'h6);
        u_host.wr(`ADDR_WP1_CTRL_MSK, 32'hff);
        u_host.rd(`ADDR_WP1_CTRL_MSK, v);
        chk_word(v, 32'hf7);
        u_host.rd(5'h1f, v);
        chk_word(v, 32'h0);
        // live status, then again after a status write
        {irq_en, attr} = {1'b1, good};
        tick(4);
        u_host.rd(`ADDR_HALT_STAT, v);
        chk_word(v, 32'h1e);
        u_host.wr(`ADDR_HALT_STAT, 32'h0);
        ack = 1'b1;
        tick(4);
        u_host.rd(`ADDR_HALT_STAT, v);
        chk_word(v, 32'h1b);
        // single step: arm while halted, exit, one instruction
        u_host.wr(`ADDR_HALT_CTRL, 32'h8);
        tick(2);
        ack = 1'b0;
        tick(3);
        insn_done = 1'b1;
        tick(1);
        insn_done = 1'b0;
        for (i = 0; i < 8 && sbrk !== 1'b1; i++) tick(1);
        chk_bit(sbrk, 1'b1);
        // every trap bit, ordinary branch never traps
        for (i = 0; i < 8; i++) begin
            u_host.wr(`ADDR_TRAP_SEL, 32'h1 << i);
            pulse_vec(8'h1 << i, 1'b0);
            chk_bit(vbrk, 1'b0);
            pulse_vec(8'h1 << i, 1'b1);
            chk_bit(vbrk, i != `TRAP_RESERVED);
        end
        // unit 1 in data mode, all fields exact
        u_host.wr(`ADDR_WP1_CTRL_VAL, 32'h13d);
        u_host.wr(`ADDR_WP1_CTRL_MSK, 32'h0);
        {ext1, addr_hit, data_hit} = 5'b11010;
        tick(2);
        chk_bit(dbrk, 1'b1);
        chk_bit(fbrk, 1'b0);
        chk_bit(link, 1'b1);
        for (i = 0; i < 4; i++) begin
            {attr, ext1} = {good, 1'b1};
            case (i)
                0: attr.data_dir = 1'b0;
                1: attr.data_size = 2'b01;
                2: attr.data_priv = 1'b0;
                default: ext1 = 1'b0;
            endcase
            tick(2);
            chk_bit(dbrk, 1'b0);
        end
        // all maskable bits excluded, wrong fields still hit
        u_host.wr(`ADDR_WP1_CTRL_MSK, 32'hff);
        attr = '{data_dir: 1'b0, data_size: 2'b01, data_priv: 1'b0, fetch_priv: 1'b0,
            compressed: 1'b1};
        tick(2);
        chk_bit(dbrk, 1'b1);
        addr_hit = 2'b00;
        u_host.wr(`ADDR_WP1_CTRL_VAL, 32'h03d);
        tick(1);
        chk_bit(link, 1'b0);
        addr_hit = 2'b10;
        tick(2);
        chk_bit(dbrk, 1'b0);
        chk_bit(link, 1'b1);
        test_reset_n = 1'b0;
        tick(1);
        chk_bit(link, 1'b0);
        test_reset_n = 1'b1;
        tick(2);
        // unit 0 fetch mode, chained on the unit 1 latch
        {addr_hit, data_hit} = 4'b0111;
        attr = '{data_dir: 1'b0, data_size: 2'b00, data_priv: 1'b0, fetch_priv: 1'b1,
            compressed: 1'b1};
        u_host.wr(`ADDR_WP0_CTRL_VAL, 32'h154);
        u_host.wr(`ADDR_WP0_CTRL_MSK, 32'h0);
        tick(2);
        chk_bit(fbrk, 1'b1);
        attr.compressed = 1'b0;
        tick(2);
        chk_bit(fbrk, 1'b0);
        {attr.compressed, attr.fetch_priv} = 2'b10;
        tick(2);
        chk_bit(fbrk, 1'b0);
        attr.fetch_priv = 1'b1;
        test_reset_n = 1'b0;
        tick(2);
        chk_bit(fbrk, 1'b0);
        // unit 0 qualified on the live unit 1 pair, chain masked off
        u_host.wr(`ADDR_WP0_CTRL_VAL, 32'h1d4);
        u_host.wr(`ADDR_WP0_CTRL_MSK, 32'h40);
        addr_hit = 2'b11;
        tick(2);
        chk_bit(pair, 1'b1);
        chk_bit(fbrk, 1'b1);
        addr_hit = 2'b01;
        tick(2);
        chk_bit(pair, 1'b0);
        chk_bit(fbrk, 1'b0);
        end_sim();
    end
endmodule : watchpoint_debug_control_bench
`default_nettype wire
